/* shared/sbc_reset_map.vh */
// Purpose: field layout and reset values for the reset-default register bank
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes: one aligned word per register; unused upper bits read as zero
`ifndef SBC_RESET_MAP_VH
`define SBC_RESET_MAP_VH

// register byte offsets
`define OFS_SYS_CFG 6'h00
`define OFS_SYS_CFG_FB 6'h04
`define OFS_PHY_CTL 6'h08
`define OFS_PHY_CTL_FB 6'h0C
`define OFS_SPECIAL 6'h10
`define OFS_USER0 6'h14
`define OFS_USER0_FB 6'h18
`define OFS_USER1 6'h1C
`define OFS_USER1_FB 6'h20
`define OFS_EVENT 6'h24
`define OFS_STATUS 6'h28

// system configuration fields (8 bits)
`define SC_WIDTH 8
`define SC_RLC 0
`define SC_AUX_LO 1
`define SC_AUX_HI 2
`define SC_CURMON 3
`define SC_WEN 4
`define SC_WSC 5
`define SC_INHIBIT_LIMP_OUTPUT_ENABLE 6
`define SC_ILC 7
`define SC_POR 8'h10

// physical layer control fields (7 bits)
`define PC_WIDTH 7
`define PC_REG 0
`define PC_PNC 1
`define PC_OTC 2
`define PC_TXC 3
`define PC_RXC 4
`define PC_ACT 5
`define PC_SPL 6
`define PC_POR 7'h04

// special mode fields (6 bits)
`define SM_WIDTH 6
`define SM_SW_DEV_MODE_INIT 0
`define SM_ERROR_PIN_EMULATION 1
`define SM_WDP_LO 2
`define SM_WDP_HI 3
`define SM_THR_LO 4
`define SM_THR_HI 5
`define SM_POR 6'h00
`define SM_THR_MASK 6'h30

// user words
`define U0_WIDTH 12
`define U0_IDV 11
`define U1_WIDTH 12
`define U1_POR 12'h000

// event command bits written to the event register
`define EV_POWER_ON 0
`define EV_START_UP 1
`define EV_RESTART 2
`define EV_FAIL_SAFE 3
`define EV_CAN_WAKE 4

`endif

/* src/sbc_reset_regs.v */
// Purpose: configuration register bank of a fail-safe CAN basis chip with reset-event defaults
// Assumes: Avalon-MM slave, one wait state on every access; mode controller raises event pulses
// Notes: events come from pins or from the event register; a pin event outranks a bus write
//
// Operation
// - wake sample control clears at power-on and is kept on all later events.
// - wake enable sets at power-on and is kept on all later events.
// - inhibit/limp level control clears at power-on and fail-safe, kept on start-up and restart.
// - inhibit/limp enable clears at power-on, clears on restart if level control is 1, sets on fail-safe.
// - partial network control clears at power-on, fail-safe, and start-up by CAN wake; else kept.
// - CAN active control clears at power-on and is kept on all later events.
// - regulator control auto at power-on and fail-safe; offline long set and tx, rx, split zero at power-on only.
// - software development mode init clears at power-on, kept on start-up and restart.
// - error pin emulation clears at power-on, kept on start-up and restart.
// - watchdog prescale resets to 00 at power-on, kept on start-up and restart.
// - main regulator reset threshold resets to 00 at power-on and restart, kept on start-up.
// - user word 0 bits 10..7 show the mask version from power-on onward.
// - user word 0 bits 6..0 show the chip type code and identity view bit clears at power-on.
// - user word 1 and its feedback clear at power-on and are kept afterwards.
// - reset length control clears at power-on, kept on start-up, set on restart and fail-safe.
// - auxiliary regulator control resets to off at power-on and is kept afterwards.
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_reset_map.vh"

module sbc_reset_regs #(
  parameter [3:0] MASK_VERSION = 4'h1, // arbitrary value
  parameter [6:0] CHIP_TYPE = 7'h55 // arbitrary value
) (
  input wire i_clk, // 40 MHz clock
  input wire i_nrst, // async reset, active low
  input wire [5:0] i_avs_address, // byte address
  input wire i_avs_read, // read request
  input wire i_avs_write, // write request
  input wire [31:0] i_avs_writedata, // write data
  input wire [3:0] i_avs_byteenable, // byte lanes
  output reg [31:0] o_avs_readdata, // read data
  output wire o_avs_waitrequest, // stall
  output reg [1:0] o_avs_response, // 00 ok, 10 slave error
  input wire i_ev_power_on, // power-on entry pulse
  input wire i_ev_start_up, // start-up entry pulse
  input wire i_ev_restart, // restart entry pulse
  input wire i_ev_fail_safe, // fail-safe entry pulse
  input wire i_can_wake_cause, // start-up caused by CAN wake-up
  output wire [7:0] o_sys_cfg, // system configuration
  output wire [6:0] o_phy_ctl, // physical layer control
  output wire [5:0] o_special, // special mode
  output wire [11:0] o_user_word0, // user word 0
  output wire [11:0] o_user_word1 // user word 1
);

  reg rst_meta;
  reg rst_sync;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire nrst = rst_sync;

  reg [7:0] sys_cfg;
  reg [6:0] phy_ctl;
  reg [5:0] special;
  reg ident_view_ctl;
  reg [11:0] user_word1;
  reg [7:0] sys_cfg_fb;
  reg [6:0] phy_ctl_fb;
  reg [11:0] user_word0_fb;
  reg [11:0] user_word1_fb;
  reg [3:0] last_event;
  reg ack;

  // requests take one wait state so read data can come from flops
  wire req = (i_avs_read | i_avs_write) & ~ack;
  assign o_avs_waitrequest = req;
  wire wr_hit = i_avs_write & ack;

  wire [11:0] user_word0 = {ident_view_ctl, MASK_VERSION, CHIP_TYPE};

  // software may also raise events through the event register
  wire hit_sys_cfg = i_avs_address == `OFS_SYS_CFG;
  wire hit_phy_ctl = i_avs_address == `OFS_PHY_CTL;
  wire hit_special = i_avs_address == `OFS_SPECIAL;
  wire hit_user0 = i_avs_address == `OFS_USER0;
  wire hit_user1 = i_avs_address == `OFS_USER1;
  wire hit_event = i_avs_address == `OFS_EVENT;
  wire lane_lo = i_avs_byteenable[0];
  wire lane_hi = i_avs_byteenable[1];

  wire ev_wr = wr_hit & hit_event & lane_lo;
  wire ev_por = i_ev_power_on | (ev_wr & i_avs_writedata[`EV_POWER_ON]);
  wire ev_sup = i_ev_start_up | (ev_wr & i_avs_writedata[`EV_START_UP]);
  wire ev_rst = i_ev_restart | (ev_wr & i_avs_writedata[`EV_RESTART]);
  wire ev_fs = i_ev_fail_safe | (ev_wr & i_avs_writedata[`EV_FAIL_SAFE]);
  wire can_wake = i_can_wake_cause | (ev_wr & i_avs_writedata[`EV_CAN_WAKE]);
  wire any_ev = ev_por | ev_sup | ev_rst | ev_fs;

  // cause of the single update that an edge may apply
  localparam [2:0] EVC_NONE = 3'h0;
  localparam [2:0] EVC_POR = 3'h1;
  localparam [2:0] EVC_FS = 3'h2;
  localparam [2:0] EVC_RST = 3'h3;
  localparam [2:0] EVC_SUP = 3'h4;
  localparam [2:0] EVC_WR = 3'h5;

  // a write meeting any event is dropped, so reset values cannot be overwritten in that cycle
  reg [2:0] ev_code;
  always @* begin
    if (ev_por) begin
      ev_code = EVC_POR;
    end else if (ev_fs) begin
      ev_code = EVC_FS;
    end else if (ev_rst) begin
      ev_code = EVC_RST;
    end else if (ev_sup) begin
      ev_code = EVC_SUP;
    end else if (wr_hit) begin
      ev_code = EVC_WR;
    end else begin
      ev_code = EVC_NONE;
    end
  end

  reg [7:0] next_sys_cfg;
  always @* begin
    next_sys_cfg = sys_cfg;
    case (ev_code)
      EVC_POR: begin
        next_sys_cfg = `SC_POR;
      end
      EVC_FS: begin
        next_sys_cfg[`SC_ILC] = 1'b0;
        next_sys_cfg[`SC_INHIBIT_LIMP_OUTPUT_ENABLE] = 1'b1;
        next_sys_cfg[`SC_RLC] = 1'b1;
      end
      EVC_RST: begin
        // enable follows the level control as it stood before the event
        if (sys_cfg[`SC_ILC]) begin
          next_sys_cfg[`SC_INHIBIT_LIMP_OUTPUT_ENABLE] = 1'b0;
        end
        next_sys_cfg[`SC_RLC] = 1'b1;
      end
      EVC_SUP: begin
        next_sys_cfg = sys_cfg;
      end
      EVC_WR: begin
        if (hit_sys_cfg && lane_lo) begin
          next_sys_cfg = i_avs_writedata[7:0];
        end
      end
      default: begin
        next_sys_cfg = sys_cfg;
      end
    endcase
  end

  reg [6:0] next_phy_ctl;
  always @* begin
    next_phy_ctl = phy_ctl;
    case (ev_code)
      EVC_POR: begin
        next_phy_ctl = `PC_POR;
      end
      EVC_FS: begin
        next_phy_ctl[`PC_REG] = 1'b0;
        next_phy_ctl[`PC_PNC] = 1'b0;
      end
      EVC_RST: begin
        next_phy_ctl = phy_ctl;
      end
      EVC_SUP: begin
        if (can_wake) begin
          next_phy_ctl[`PC_PNC] = 1'b0;
        end
      end
      EVC_WR: begin
        if (hit_phy_ctl && lane_lo) begin
          next_phy_ctl = i_avs_writedata[6:0];
        end
      end
      default: begin
        next_phy_ctl = phy_ctl;
      end
    endcase
  end

  reg [5:0] next_special;
  always @* begin
    next_special = special;
    case (ev_code)
      EVC_POR: begin
        next_special = `SM_POR;
      end
      EVC_RST: begin
        next_special = special & ~`SM_THR_MASK;
      end
      EVC_FS, EVC_SUP: begin
        next_special = special;
      end
      EVC_WR: begin
        if (hit_special && lane_lo) begin
          next_special = i_avs_writedata[5:0];
        end
      end
      default: begin
        next_special = special;
      end
    endcase
  end

  reg next_ident;
  always @* begin
    next_ident = ident_view_ctl;
    case (ev_code)
      EVC_POR: begin
        next_ident = 1'b0;
      end
      EVC_FS, EVC_RST, EVC_SUP: begin
        next_ident = ident_view_ctl;
      end
      EVC_WR: begin
        if (hit_user0 && lane_hi) begin
          next_ident = i_avs_writedata[`U0_IDV];
        end
      end
      default: begin
        next_ident = ident_view_ctl;
      end
    endcase
  end

  reg [11:0] next_user_word1;
  always @* begin
    next_user_word1 = user_word1;
    case (ev_code)
      EVC_POR: begin
        next_user_word1 = `U1_POR;
      end
      EVC_FS, EVC_RST, EVC_SUP: begin
        next_user_word1 = user_word1;
      end
      EVC_WR: begin
        if (hit_user1 && lane_lo) begin
          next_user_word1[7:0] = i_avs_writedata[7:0];
        end
        if (hit_user1 && lane_hi) begin
          next_user_word1[11:8] = i_avs_writedata[11:8];
        end
      end
      default: begin
        next_user_word1 = user_word1;
      end
    endcase
  end

  always @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      sys_cfg <= `SC_POR;
      phy_ctl <= `PC_POR;
      special <= `SM_POR;
      ident_view_ctl <= 1'b0;
      user_word1 <= `U1_POR;
    end else begin
      sys_cfg <= next_sys_cfg;
      phy_ctl <= next_phy_ctl;
      special <= next_special;
      ident_view_ctl <= next_ident;
      user_word1 <= next_user_word1;
    end
  end

  // copies load the same next value as their control word, so a read never sees them lag
  always @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      sys_cfg_fb <= `SC_POR;
      phy_ctl_fb <= `PC_POR;
      user_word0_fb <= {1'b0, MASK_VERSION, CHIP_TYPE};
      user_word1_fb <= `U1_POR;
    end else begin
      sys_cfg_fb <= next_sys_cfg;
      phy_ctl_fb <= next_phy_ctl;
      user_word0_fb <= {next_ident, MASK_VERSION, CHIP_TYPE};
      user_word1_fb <= next_user_word1;
    end
  end

  always @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      last_event <= 4'h0;
      ack <= 1'b0;
    end else begin
      if (any_ev) begin
        last_event <= {ev_code == EVC_FS, ev_code == EVC_RST, ev_code == EVC_SUP, ev_code == EVC_POR};
      end
      ack <= req;
    end
  end

  reg [31:0] rd_mux;
  reg rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (i_avs_address)
      `OFS_SYS_CFG: rd_mux[7:0] = sys_cfg;
      `OFS_SYS_CFG_FB: rd_mux[7:0] = sys_cfg_fb;
      `OFS_PHY_CTL: rd_mux[6:0] = phy_ctl;
      `OFS_PHY_CTL_FB: rd_mux[6:0] = phy_ctl_fb;
      `OFS_SPECIAL: rd_mux[5:0] = special;
      `OFS_USER0: rd_mux[11:0] = user_word0;
      `OFS_USER0_FB: rd_mux[11:0] = user_word0_fb;
      `OFS_USER1: rd_mux[11:0] = user_word1;
      `OFS_USER1_FB: rd_mux[11:0] = user_word1_fb;
      `OFS_EVENT: rd_mux = 32'h0000_0000;
      `OFS_STATUS: rd_mux[3:0] = last_event;
      default: rd_err = 1'b1;
    endcase
  end

  // unmapped addresses answer with a slave error and zero data
  always @(posedge i_clk or negedge nrst) begin
    if (!nrst) begin
      o_avs_readdata <= 32'h0000_0000;
      o_avs_response <= 2'h0;
    end else if (req) begin
      o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
      o_avs_response <= rd_err ? 2'h2 : 2'h0;
    end
  end

  assign o_sys_cfg = sys_cfg;
  assign o_phy_ctl = phy_ctl;
  assign o_special = special;
  assign o_user_word0 = user_word0;
  assign o_user_word1 = user_word1;

endmodule // sbc_reset_regs
`default_nettype wire

/* tb/mode_ctl_model.sv */
// Purpose: mode controller raising entry event pulses
// Assumes: same clock as the register bank
// Notes: wake cause flips after the pulse so it only counts with it
`timescale 1ns/1ps
`default_nettype none
module mode_ctl_model (
  input wire i_clk, // clock
  output logic [3:0] o_ev, // {fail-safe, restart, start-up, power-on}
  output logic o_can_wake_cause // wake cause level
);
  initial begin
    o_ev = 4'h0;
    o_can_wake_cause = 1'b0;
  end
  task fire(input logic [3:0] sel, input logic wake);
    @(posedge i_clk);
    o_ev <= sel;
    o_can_wake_cause <= wake;
    @(posedge i_clk);
    o_ev <= 4'h0;
    o_can_wake_cause <= ~wake;
  endtask
endmodule // mode_ctl_model
`default_nettype wire

/* tb/sbc_reset_regs_chk.sv */
// Purpose: assertions on the reset-default register bank
// Assumes: one-cycle event pulses, single clock
// Notes: higher-priority events masked from lower ones
`timescale 1ns/1ps
`default_nettype none
`include "sbc_reset_map.vh"
module sbc_reset_regs_chk #(
  parameter [3:0] MASK_VERSION = 4'h1, // arbitrary value
  parameter [6:0] CHIP_TYPE = 7'h55 // arbitrary value
) (
  input wire i_clk, // clock
  input wire i_nrst, // reset, active low
  input wire i_ev_power_on, // power-on pulse
  input wire i_ev_start_up, // start-up pulse
  input wire i_ev_restart, // restart pulse
  input wire i_ev_fail_safe, // fail-safe pulse
  input wire i_can_wake_cause, // wake cause
  input wire [7:0] o_sys_cfg, // system config
  input wire [6:0] o_phy_ctl, // phy control
  input wire [5:0] o_special, // special mode
  input wire [11:0] o_user_word0, // user word 0
  input wire [11:0] o_user_word1 // user word 1
);
  wire fs = i_ev_fail_safe && !i_ev_power_on;
  wire rs = i_ev_restart && !i_ev_fail_safe && !i_ev_power_on;
  wire su = i_ev_start_up && !i_ev_restart && !i_ev_fail_safe && !i_ev_power_on;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_por_sys; i_ev_power_on |=> o_sys_cfg == `SC_POR; endproperty
  a_por_sys: assert property (p_por_sys) else $error("sys cfg not default");
  property p_por_phy; i_ev_power_on |=> o_phy_ctl == `PC_POR; endproperty
  a_por_phy: assert property (p_por_phy) else $error("phy ctl not default");
  property p_por_sm; i_ev_power_on |=> o_special == 6'h00 && o_user_word1 == 12'h000 && !o_user_word0[11]; endproperty
  a_por_sm: assert property (p_por_sm) else $error("special or user not default");
  property p_fs_sys; fs |=> o_sys_cfg == {2'b01, $past(o_sys_cfg[5:1]), 1'b1}; endproperty
  a_fs_sys: assert property (p_fs_sys) else $error("fail-safe sys cfg wrong");
  property p_fs_phy; fs |=> o_phy_ctl == {$past(o_phy_ctl[6:2]), 2'b00}; endproperty
  a_fs_phy: assert property (p_fs_phy) else $error("fail-safe phy wrong");
  property p_rs;
    rs |=> o_sys_cfg == {$past(o_sys_cfg[7]), $past(o_sys_cfg[6]) & !$past(o_sys_cfg[7]), $past(o_sys_cfg[5:1]), 1'b1}
      && o_special == ($past(o_special) & ~`SM_THR_MASK) && $stable(o_phy_ctl);
  endproperty
  a_rs: assert property (p_rs) else $error("restart update wrong");
  property p_su;
    su |=> $stable(o_sys_cfg) && $stable(o_special) && o_phy_ctl[6:2] == $past(o_phy_ctl[6:2])
      && o_phy_ctl[0] == $past(o_phy_ctl[0]) && o_phy_ctl[1] == ($past(o_phy_ctl[1]) & !$past(i_can_wake_cause));
  endproperty
  a_su: assert property (p_su) else $error("start-up update wrong");
  property p_u0; o_user_word0[10:0] == {MASK_VERSION, CHIP_TYPE}; endproperty
  a_u0: assert property (p_u0) else $error("user word 0 identity wrong");
  property p_u1; (fs || rs || su) |=> $stable(o_user_word1) && $stable(o_user_word0); endproperty
  a_u1: assert property (p_u1) else $error("user words changed");
endmodule // sbc_reset_regs_chk
bind sbc_reset_regs sbc_reset_regs_chk #(.MASK_VERSION(MASK_VERSION), .CHIP_TYPE(CHIP_TYPE)) u_chk (.i_clk, .i_nrst,
  .i_ev_power_on, .i_ev_start_up, .i_ev_restart, .i_ev_fail_safe, .i_can_wake_cause, .o_sys_cfg, .o_phy_ctl,
  .o_special, .o_user_word0, .o_user_word1);
`default_nettype wire

/* tb/sbc_reset_regs_test.sv */
// Purpose: register-level test of the reset-default bank
// Assumes: one wait state, events from the mode model
// Notes: identity parameters set to arbitrary values
`timescale 1ns/1ps
`default_nettype none
`include "sbc_reset_map.vh"
module sbc_register_reset_defaults_test;
  logic clk, nrst, rd, wr, wt;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] resp, rsv;
  logic [3:0] ev;
  logic wake;
  logic [11:0] u0, u1;
  logic [7:0] sc;
  logic [6:0] pc;
  logic [5:0] sm;
  int fails = 0, total_checks = 0, cycles = 0;
  mode_ctl_model mc (.i_clk(clk), .o_ev(ev), .o_can_wake_cause(wake));
  sbc_reset_regs #(.MASK_VERSION(4'hA), .CHIP_TYPE(7'h2B)) DUT (.i_clk(clk), .i_nrst(nrst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h3), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wt), .o_avs_response(resp), .i_ev_power_on(ev[0]), .i_ev_start_up(ev[1]),
    .i_ev_restart(ev[2]), .i_ev_fail_safe(ev[3]), .i_can_wake_cause(wake), .o_sys_cfg(sc), .o_phy_ctl(pc),
    .o_special(sm), .o_user_word0(u0), .o_user_word1(u1));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin // far beyond the few hundred cycles needed
      fails = fails + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    addr <= a;
    wdata <= wd;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    // taken edge: the answer is read before the request drops
    rdv = rdata;
    rsv = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rdv, exp);
  endtask
  task pair(input logic [5:0] a, input logic [31:0] exp);
    rchk(a, exp);
    rchk(a + 6'h04, exp); // feedback copy matches
  endtask
  task defaults;
    pair(`OFS_SYS_CFG, 32'h10);
    pair(`OFS_PHY_CTL, 32'h04);
    rchk(`OFS_SPECIAL, 32'h00);
    pair(`OFS_USER0, 32'h52B);
    pair(`OFS_USER1, 32'h000);
  endtask
  initial begin
    nrst = 0; rd = 0; wr = 0; addr = 6'h00; wdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    defaults;
    bus(1, `OFS_SYS_CFG, 32'hFE); bus(1, `OFS_PHY_CTL, 32'h7F); bus(1, `OFS_SPECIAL, 32'h3F);
    bus(1, `OFS_USER1, 32'hFFF); bus(1, `OFS_USER0, 32'h800); bus(1, `OFS_USER1_FB, 32'h0);
    mc.fire(4'h2, 1'b0);
    pair(`OFS_SYS_CFG, 32'hFE);
    pair(`OFS_PHY_CTL, 32'h7F);
    rchk(`OFS_SPECIAL, 32'h3F);
    pair(`OFS_USER0, 32'hD2B);
    pair(`OFS_USER1, 32'hFFF);
    mc.fire(4'h2, 1'b1);
    pair(`OFS_PHY_CTL, 32'h7D);
    mc.fire(4'h4, 1'b0);
    pair(`OFS_SYS_CFG, 32'hBF);
    rchk(`OFS_SPECIAL, 32'h0F);
    pair(`OFS_PHY_CTL, 32'h7D);
    bus(1, `OFS_SYS_CFG, 32'h40);
    mc.fire(4'h4, 1'b0);
    pair(`OFS_SYS_CFG, 32'h41);
    bus(1, `OFS_SYS_CFG, 32'hFE); bus(1, `OFS_PHY_CTL, 32'h7F); bus(1, `OFS_SPECIAL, 32'h3F);
    mc.fire(4'h8, 1'b0);
    pair(`OFS_SYS_CFG, 32'h7F);
    pair(`OFS_PHY_CTL, 32'h7C);
    rchk(`OFS_USER1, 32'hFFF);
    bus(0, 6'h3C, 32'h0);
    check("unmapped response", {30'h0, rsv}, 32'h2);
    check("unmapped data", rdv, 32'h0);
    rchk(`OFS_SPECIAL, 32'h3F);
    mc.fire(4'h1, 1'b1);
    defaults;
    rchk(`OFS_STATUS, 32'h1);
    bus(1, `OFS_SYS_CFG, 32'hC0); bus(1, `OFS_EVENT, 32'h04);
    pair(`OFS_SYS_CFG, 32'h81);
    rchk(`OFS_STATUS, 32'h4);
    bus(1, `OFS_PHY_CTL, 32'h06); bus(1, `OFS_EVENT, 32'h12);
    pair(`OFS_PHY_CTL, 32'h04);
    rchk(`OFS_STATUS, 32'h2);
    tally_and_finish;
  end
endmodule // sbc_register_reset_defaults_test
`default_nettype wire
